// ### hw/mofd_cfg.svh
// encodings and fixed counts for the move and operand field decoder
`ifndef MOFD_CFG_SVH
`define MOFD_CFG_SVH

// operation codes presented on op_in
`define MOFD_OP_NOP 3'h0
`define MOFD_OP_MAC 3'h1
`define MOFD_OP_ADD 3'h2
`define MOFD_OP_MOVW 3'h3
`define MOFD_OP_MOVL 3'h4
`define MOFD_OP_MOVXW 3'h5
`define MOFD_OP_MOVXL 3'h6

// register field codes shared by all move fields
`define MOFD_F_A 4'h0
`define MOFD_F_D 4'h3
`define MOFD_F_Y 4'h4
`define MOFD_F_X0 4'h5
`define MOFD_F_Y0 4'h6
`define MOFD_F_Y1 4'h7
`define MOFD_F_R0 4'h8
`define MOFD_F_N 4'hE

// sign prefix codes of the multiply operand
`define MOFD_SIGN_NONE 2'h0
`define MOFD_SIGN_PLUS 2'h1
`define MOFD_SIGN_MINUS 2'h2

// dual-read addressing modes
`define MOFD_AM_INC 2'h0
`define MOFD_AM_DEC 2'h1
`define MOFD_AM_PN 2'h2
`define MOFD_AM_PN3 2'h3

// dual-read pointers and destinations
`define MOFD_PTR_R2 3'h2
`define MOFD_PTR_LIM 3'h4
`define MOFD_DD_X0 2'h0
`define MOFD_DD_Y0 2'h1
`define MOFD_DD_BAD 2'h3

// counts
`define MOFD_MAC_CYC 2'h1
`define MOFD_MAC_WRD 2'h1
`define MOFD_ADD_OPS 2'h2
`define MOFD_NONE_CNT 2'h0

// illegal cause bit positions
`define MOFD_CAUSE_W 10
`define MOFD_C_MACOP 0
`define MOFD_C_SIGN 1
`define MOFD_C_ADDN 2
`define MOFD_C_R1PTR 3
`define MOFD_C_R1MODE 4
`define MOFD_C_R1DST 5
`define MOFD_C_R2MODE 6
`define MOFD_C_R2DST 7
`define MOFD_C_SRC 8
`define MOFD_C_DST 9

`endif

// ### hw/mofd_pkg.sv
// types of the move and operand field decoder
package mofd_pkg;
    typedef enum logic [4:0] {
        MOFD_R_NONE, MOFD_R_A, MOFD_R_B, MOFD_R_C, MOFD_R_D, MOFD_R_Y,
        MOFD_R_X0, MOFD_R_Y0, MOFD_R_Y1,
        MOFD_R_R0, MOFD_R_R1, MOFD_R_R2, MOFD_R_R3, MOFD_R_R4, MOFD_R_R5,
        MOFD_R_N
    } mofd_reg_e;
    // none, upper_word_portion only, plain 16-bit word, upper:lower long, whole accumulator
    typedef enum logic [2:0] {
        MOFD_P_NONE, MOFD_P_UPPER, MOFD_P_WORD, MOFD_P_LONG, MOFD_P_WHOLE
    } mofd_part_e;
    typedef enum logic [1:0] {
        MOFD_K_WORD, MOFD_K_LONG, MOFD_K_XWORD, MOFD_K_XLONG
    } mofd_kind_e;
endpackage : mofd_pkg

// ### hw/mofd_ifs.sv
// carriers between the decoder top and its field helpers
`timescale 1ns/1ps
interface mofd_map_if;
    import mofd_pkg::*;
    logic [3:0] code;
    mofd_kind_e kind;
    logic whole_name;
    mofd_reg_e sel;
    mofd_part_e part;
    logic legal;
    logic clr_low;
    logic sat;
    modport mapper (input code, kind, whole_name, output sel, part, legal, clr_low, sat);
    modport user (output code, kind, whole_name, input sel, part, legal, clr_low, sat);
endinterface : mofd_map_if

interface mofd_dual_if;
    logic [2:0] ptr1;
    logic [1:0] mode1;
    logic [1:0] dst1;
    logic [1:0] mode2;
    logic [1:0] dst2;
    logic bad_ptr1;
    logic bad_mode1;
    logic bad_dst1;
    logic bad_mode2;
    logic bad_dst2;
    modport checker_side (input ptr1, mode1, dst1, mode2, dst2,
                          output bad_ptr1, bad_mode1, bad_dst1, bad_mode2, bad_dst2);
    modport user (output ptr1, mode1, dst1, mode2, dst2,
                  input bad_ptr1, bad_mode1, bad_dst1, bad_mode2, bad_dst2);
endinterface : mofd_dual_if

// ### hw/mofd_field_map.sv
// maps one move register-field code to a register and a portion
`timescale 1ns/1ps
`include "mofd_cfg.svh"
module mofd_field_map import mofd_pkg::*; #(
    parameter bit IS_DEST = 1'b0
) (
    mofd_map_if.mapper m
);
    //////////////////////////////////////////////////////////////////////
    // code to register; codes above N fall to none
    function automatic mofd_reg_e code_reg(input logic [3:0] c);
        mofd_reg_e r;
        r = MOFD_R_NONE;
        if (c <= `MOFD_F_N) begin
            r = mofd_reg_e'(5'(c) + 5'h01);
        end
        return r;
    endfunction : code_reg

    //////////////////////////////////////////////////////////////////////
    // legality, portion and side effects of the selected register
    always_comb begin
        logic is_acc;
        logic is_agu;
        logic is_long;
        is_acc = (m.code <= `MOFD_F_D);
        is_agu = (m.code >= `MOFD_F_R0) && (m.code <= `MOFD_F_N);
        is_long = (m.kind == MOFD_K_LONG) || (m.kind == MOFD_K_XLONG);
        m.legal = 1'b0;
        m.part = MOFD_P_NONE;
        m.clr_low = 1'b0;
        m.sat = 1'b0;
        case (m.kind)
            MOFD_K_WORD: begin
                m.legal = (m.code <= `MOFD_F_Y1) && (IS_DEST || m.code != `MOFD_F_Y);
            end
            MOFD_K_LONG: begin
                m.legal = (m.code <= `MOFD_F_Y);
            end
            MOFD_K_XWORD: begin
                // Y never reads as a word source, matching the core move field
                m.legal = (m.code <= `MOFD_F_N) && (IS_DEST || m.code != `MOFD_F_Y);
            end
            default: begin
                m.legal = (m.code <= `MOFD_F_Y) || is_agu;
            end
        endcase
        if (!m.legal) begin
            m.part = MOFD_P_NONE;
        end else if (is_long) begin
            m.part = (is_acc && IS_DEST) ? MOFD_P_WHOLE : MOFD_P_LONG;
        end else if (is_acc) begin
            m.part = IS_DEST ? MOFD_P_WHOLE : MOFD_P_UPPER;
        end else if (m.code == `MOFD_F_Y) begin
            m.part = MOFD_P_UPPER;
            m.clr_low = 1'b1;
        end else begin
            m.part = MOFD_P_WORD;
        end
        // a whole-accumulator name on a word read routes through the limiter
        m.sat = m.legal && !IS_DEST && !is_long && is_acc && m.whole_name;
        m.sel = m.legal ? code_reg(m.code) : MOFD_R_NONE;
    end
endmodule : mofd_field_map

// ### hw/mofd_dual_check.sv
// addressing and destination checks of a dual-read parallel move
`timescale 1ns/1ps
`include "mofd_cfg.svh"
module mofd_dual_check (
    mofd_dual_if.checker_side d
);
    //////////////////////////////////////////////////////////////////////
    // first read: Rj pointers minus R2, no post-decrement, no N3, not into X0; second read: no PN update, not into Y0
    always_comb begin
        d.bad_ptr1 = (d.ptr1 == `MOFD_PTR_R2) || (d.ptr1 >= `MOFD_PTR_LIM);
        d.bad_mode1 = (d.mode1 == `MOFD_AM_DEC) || (d.mode1 == `MOFD_AM_PN3);
        d.bad_dst1 = (d.dst1 == `MOFD_DD_X0) || (d.dst1 == `MOFD_DD_BAD);
        d.bad_mode2 = (d.mode2 == `MOFD_AM_PN);
        d.bad_dst2 = (d.dst2 == `MOFD_DD_Y0) || (d.dst2 == `MOFD_DD_BAD);
    end
endmodule : mofd_dual_check

// ### hw/mofd_decoder.sv
// operand legality and move register-field decoder, registered outputs
//
// How it works
// - multiply takes two word-set sources, accumulates into eight-register set, one cycle, one word.
// - minus prefix negates the product; plus or no prefix leaves it unchanged.
// - add naming three register operands is rejected; add takes exactly two.
// - dual read: pointer register two is illegal for the first read.
// - dual read: post-decrement is illegal on the first read.
// - dual read: x0 may not be the first read's destination.
// - second read allows post-increment, post-decrement, post-update by index three only.
// - dual read: y0 may not be the second read's destination.
// - word source field picks accumulator upper words or three data registers.
// - word destination picks whole accumulator, long register or data register.
// - a word written to the long register fills upper half, clears lower.
// - long source picks upper:lower of four accumulators or long register.
// - long destination picks a whole accumulator or the long register.
// - extended word source adds six pointers and general index, fourteen total.
// - extended word destination adds seven ADDRESS_GENERATION_UNIT registers, same lower-half clear.
// - extended long source adds seven ADDRESS_GENERATION_UNIT registers to five long sources.
// - extended long destination: accumulators, long register, seven ADDRESS_GENERATION_UNIT registers.
// - naming an accumulator whole as a word-move source turns limiter saturation on; long moves never saturate.
// - in word moves the long register is a destination only, never a source.
`timescale 1ns/1ps
`include "mofd_cfg.svh"
module mofd_decoder import mofd_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic valid_in,
    input wire logic [2:0] op_in,
    input wire logic [1:0] sign_in,
    input wire logic [2:0] mult_a_in,
    input wire logic [2:0] mult_b_in,
    input wire logic [2:0] acc_in,
    input wire logic [1:0] add_ops_in,
    input wire logic [3:0] src_code_in,
    input wire logic [3:0] dst_code_in,
    input wire logic src_whole_in,
    input wire logic dual_par_in,
    input wire logic [2:0] ptr1_in,
    input wire logic [1:0] mode1_in,
    input wire logic [1:0] dst1_in,
    input wire logic [1:0] mode2_in,
    input wire logic [1:0] dst2_in,
    output logic dec_valid_out,
    output logic illegal_out,
    output logic [`MOFD_CAUSE_W-1:0] cause_out,
    output logic negate_out,
    output mofd_reg_e mult_a_sel_out,
    output mofd_reg_e mult_b_sel_out,
    output mofd_reg_e acc_sel_out,
    output mofd_reg_e src_sel_out,
    output mofd_part_e src_part_out,
    output mofd_reg_e dst_sel_out,
    output mofd_part_e dst_part_out,
    output logic clr_low_out,
    output logic sat_out,
    output logic [1:0] cycles_out,
    output logic [1:0] words_out
);
    //////////////////////////////////////////////////////////////////////
    // helpers
    mofd_map_if src_if ();
    mofd_map_if dst_if ();
    mofd_dual_if dual_if ();

    mofd_field_map #(
        .IS_DEST(1'b0)
    ) u_src_map (
        .m(src_if.mapper)
    );

    mofd_field_map #(
        .IS_DEST(1'b1)
    ) u_dst_map (
        .m(dst_if.mapper)
    );

    mofd_dual_check u_dual (
        .d(dual_if.checker_side)
    );

    //////////////////////////////////////////////////////////////////////
    // state
    logic dec_valid_reg;
    logic dec_valid_next;
    logic illegal_reg;
    logic illegal_next;
    logic [`MOFD_CAUSE_W-1:0] cause_reg;
    logic [`MOFD_CAUSE_W-1:0] cause_next;
    logic negate_reg;
    logic negate_next;
    mofd_reg_e mult_a_reg;
    mofd_reg_e mult_a_next;
    mofd_reg_e mult_b_reg;
    mofd_reg_e mult_b_next;
    mofd_reg_e acc_reg;
    mofd_reg_e acc_next;
    mofd_reg_e src_sel_reg;
    mofd_reg_e src_sel_next;
    mofd_part_e src_part_reg;
    mofd_part_e src_part_next;
    mofd_reg_e dst_sel_reg;
    mofd_reg_e dst_sel_next;
    mofd_part_e dst_part_reg;
    mofd_part_e dst_part_next;
    logic clr_low_reg;
    logic clr_low_next;
    logic sat_reg;
    logic sat_next;
    logic [1:0] cycles_reg;
    logic [1:0] cycles_next;
    logic [1:0] words_reg;
    logic [1:0] words_next;

    logic is_move;
    logic dual_on;
    logic [`MOFD_CAUSE_W-1:0] cause;

    //////////////////////////////////////////////////////////////////////
    // word source set of the multiplier: every field code but Y
    function automatic mofd_reg_e mult_reg(input logic [2:0] c);
        mofd_reg_e r;
        r = MOFD_R_NONE;
        if ({1'b0, c} != `MOFD_F_Y) begin
            r = mofd_reg_e'(5'(c) + 5'h01);
        end
        return r;
    endfunction : mult_reg

    // accumulate set: all eight codes are legal
    function automatic mofd_reg_e acc_reg_of(input logic [2:0] c);
        return mofd_reg_e'(5'(c) + 5'h01);
    endfunction : acc_reg_of

    //////////////////////////////////////////////////////////////////////
    // feed the field helpers
    always_comb begin
        src_if.code = src_code_in;
        dst_if.code = dst_code_in;
        src_if.whole_name = src_whole_in;
        dst_if.whole_name = 1'b0;
        case (op_in)
            `MOFD_OP_MOVL: begin
                src_if.kind = MOFD_K_LONG;
            end
            `MOFD_OP_MOVXW: begin
                src_if.kind = MOFD_K_XWORD;
            end
            `MOFD_OP_MOVXL: begin
                src_if.kind = MOFD_K_XLONG;
            end
            default: begin
                src_if.kind = MOFD_K_WORD;
            end
        endcase
        dst_if.kind = src_if.kind;
    end

    // dual-read fields go straight to their checker
    always_comb begin
        dual_if.ptr1 = ptr1_in;
        dual_if.mode1 = mode1_in;
        dual_if.dst1 = dst1_in;
        dual_if.mode2 = mode2_in;
        dual_if.dst2 = dst2_in;
    end

    //////////////////////////////////////////////////////////////////////
    // illegal causes, gathered per operation
    always_comb begin
        is_move = (op_in >= `MOFD_OP_MOVW) && (op_in <= `MOFD_OP_MOVXL);
        // a dual read rides only on multiply or add
        dual_on = dual_par_in && ((op_in == `MOFD_OP_MAC) || (op_in == `MOFD_OP_ADD));
        cause = '0;
        if (op_in == `MOFD_OP_MAC) begin
            cause[`MOFD_C_MACOP] = (mult_reg(mult_a_in) == MOFD_R_NONE)
                || (mult_reg(mult_b_in) == MOFD_R_NONE);
            cause[`MOFD_C_SIGN] = (sign_in != `MOFD_SIGN_NONE) && (sign_in != `MOFD_SIGN_PLUS)
                && (sign_in != `MOFD_SIGN_MINUS);
        end
        if (op_in == `MOFD_OP_ADD) begin
            cause[`MOFD_C_ADDN] = (add_ops_in != `MOFD_ADD_OPS);
        end
        if (dual_on) begin
            cause[`MOFD_C_R1PTR] = dual_if.bad_ptr1;
            cause[`MOFD_C_R1MODE] = dual_if.bad_mode1;
            cause[`MOFD_C_R1DST] = dual_if.bad_dst1;
            cause[`MOFD_C_R2MODE] = dual_if.bad_mode2;
            cause[`MOFD_C_R2DST] = dual_if.bad_dst2;
        end
        if (is_move) begin
            cause[`MOFD_C_SRC] = !src_if.legal;
            cause[`MOFD_C_DST] = !dst_if.legal;
        end
        // unused operation codes are themselves out of the permitted set
        if (op_in > `MOFD_OP_MOVXL) begin
            cause[`MOFD_C_MACOP] = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // next decoded result; an illegal word drives every select to none
    always_comb begin
        dec_valid_next = valid_in;
        illegal_next = 1'b0;
        cause_next = '0;
        negate_next = 1'b0;
        mult_a_next = MOFD_R_NONE;
        mult_b_next = MOFD_R_NONE;
        acc_next = MOFD_R_NONE;
        src_sel_next = MOFD_R_NONE;
        src_part_next = MOFD_P_NONE;
        dst_sel_next = MOFD_R_NONE;
        dst_part_next = MOFD_P_NONE;
        clr_low_next = 1'b0;
        sat_next = 1'b0;
        cycles_next = `MOFD_NONE_CNT;
        words_next = `MOFD_NONE_CNT;
        if (valid_in && (cause != '0)) begin
            illegal_next = 1'b1;
            cause_next = cause;
        end else if (valid_in && (op_in == `MOFD_OP_MAC)) begin
            mult_a_next = mult_reg(mult_a_in);
            mult_b_next = mult_reg(mult_b_in);
            acc_next = acc_reg_of(acc_in);
            negate_next = (sign_in == `MOFD_SIGN_MINUS);
            cycles_next = `MOFD_MAC_CYC;
            words_next = `MOFD_MAC_WRD;
        end else if (valid_in && is_move) begin
            src_sel_next = src_if.sel;
            src_part_next = src_if.part;
            dst_sel_next = dst_if.sel;
            dst_part_next = dst_if.part;
            clr_low_next = dst_if.clr_low;
            sat_next = src_if.sat;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // registers; outputs come straight from here
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dec_valid_reg <= 1'b0;
            illegal_reg <= 1'b0;
            cause_reg <= '0;
            negate_reg <= 1'b0;
            mult_a_reg <= MOFD_R_NONE;
            mult_b_reg <= MOFD_R_NONE;
            acc_reg <= MOFD_R_NONE;
            src_sel_reg <= MOFD_R_NONE;
            src_part_reg <= MOFD_P_NONE;
            dst_sel_reg <= MOFD_R_NONE;
            dst_part_reg <= MOFD_P_NONE;
            clr_low_reg <= 1'b0;
            sat_reg <= 1'b0;
            cycles_reg <= `MOFD_NONE_CNT;
            words_reg <= `MOFD_NONE_CNT;
        end else begin
            dec_valid_reg <= dec_valid_next;
            illegal_reg <= illegal_next;
            cause_reg <= cause_next;
            negate_reg <= negate_next;
            mult_a_reg <= mult_a_next;
            mult_b_reg <= mult_b_next;
            acc_reg <= acc_next;
            src_sel_reg <= src_sel_next;
            src_part_reg <= src_part_next;
            dst_sel_reg <= dst_sel_next;
            dst_part_reg <= dst_part_next;
            clr_low_reg <= clr_low_next;
            sat_reg <= sat_next;
            cycles_reg <= cycles_next;
            words_reg <= words_next;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // outputs
    assign dec_valid_out = dec_valid_reg;
    assign illegal_out = illegal_reg;
    assign cause_out = cause_reg;
    assign negate_out = negate_reg;
    assign mult_a_sel_out = mult_a_reg;
    assign mult_b_sel_out = mult_b_reg;
    assign acc_sel_out = acc_reg;
    assign src_sel_out = src_sel_reg;
    assign src_part_out = src_part_reg;
    assign dst_sel_out = dst_sel_reg;
    assign dst_part_out = dst_part_reg;
    assign clr_low_out = clr_low_reg;
    assign sat_out = sat_reg;
    assign cycles_out = cycles_reg;
    assign words_out = words_reg;
endmodule : mofd_decoder

// ### tb/mofd_decoder_chk.sv
// concurrent checks of the move and operand field decoder ports
`timescale 1ns/1ps
`include "mofd_cfg.svh"
module mofd_decoder_chk import mofd_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic valid_in,
    input wire logic [2:0] op_in,
    input wire logic [1:0] sign_in,
    input wire logic [1:0] add_ops_in,
    input wire logic [3:0] src_code_in,
    input wire logic [3:0] dst_code_in,
    input wire logic src_whole_in,
    input wire logic dual_par_in,
    input wire logic [2:0] ptr1_in,
    input wire logic [1:0] mode1_in,
    input wire logic [1:0] dst1_in,
    input wire logic [1:0] mode2_in,
    input wire logic [1:0] dst2_in,
    input wire logic dec_valid_out,
    input wire logic illegal_out,
    input wire logic [`MOFD_CAUSE_W-1:0] cause_out,
    input wire logic negate_out,
    input wire mofd_reg_e src_sel_out,
    input wire mofd_reg_e dst_sel_out,
    input wire logic clr_low_out,
    input wire logic sat_out,
    input wire logic [1:0] cycles_out,
    input wire logic [1:0] words_out
);
    // dual read rides on multiply or add
    wire logic dual_rd = valid_in && dual_par_in && (op_in == `MOFD_OP_MAC || op_in == `MOFD_OP_ADD);

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    ////////////////////////////////////////////////////////////////////////////////
    // answers one edge later
    valid_follow_a: assert property (valid_in |=> dec_valid_out) else $error("decode valid missing");
    mac_counts_a: assert property (valid_in && op_in == `MOFD_OP_MAC |=>
        (cycles_out == `MOFD_MAC_CYC && words_out == `MOFD_MAC_WRD) != illegal_out) else $error("multiply counts");
    negate_on_a: assert property (valid_in && op_in == `MOFD_OP_MAC && sign_in == `MOFD_SIGN_MINUS |=>
        negate_out != illegal_out) else $error("product not negated");
    negate_off_a: assert property (op_in != `MOFD_OP_MAC || sign_in != `MOFD_SIGN_MINUS |=>
        !negate_out) else $error("stray negate");
    add_count_a: assert property (valid_in && op_in == `MOFD_OP_ADD && add_ops_in != `MOFD_ADD_OPS |=>
        illegal_out && cause_out[`MOFD_C_ADDN]) else $error("add count");
    ptr_two_a: assert property (dual_rd && ptr1_in == `MOFD_PTR_R2 |=> cause_out[`MOFD_C_R1PTR])
        else $error("read1 pointer two");
    read1_mode_a: assert property (dual_rd && mode1_in == `MOFD_AM_DEC |=> cause_out[`MOFD_C_R1MODE])
        else $error("read1 post-decrement");
    read1_dst_a: assert property (dual_rd && dst1_in == `MOFD_DD_X0 |=> cause_out[`MOFD_C_R1DST])
        else $error("read1 into x0");
    read2_mode_a: assert property (dual_rd |=> cause_out[`MOFD_C_R2MODE] == $past(mode2_in == `MOFD_AM_PN))
        else $error("read2 mode");
    read2_dst_a: assert property (dual_rd && dst2_in == `MOFD_DD_Y0 |=> cause_out[`MOFD_C_R2DST])
        else $error("read2 into y0");
    long_clear_a: assert property (valid_in && op_in inside {`MOFD_OP_MOVW, `MOFD_OP_MOVXW} &&
        dst_code_in == `MOFD_F_Y |=> clr_low_out != illegal_out) else $error("no clear");
    y_no_src_a: assert property (valid_in && op_in == `MOFD_OP_MOVW && src_code_in == `MOFD_F_Y |=>
        illegal_out && cause_out[`MOFD_C_SRC]) else $error("y as source");
    sat_whole_a: assert property (valid_in && op_in == `MOFD_OP_MOVW && src_code_in == `MOFD_F_A |=>
        illegal_out || sat_out == $past(src_whole_in)) else $error("limiter choice wrong");
    illegal_none_a: assert property (illegal_out |-> src_sel_out == MOFD_R_NONE &&
        dst_sel_out == MOFD_R_NONE && !negate_out && cycles_out == `MOFD_NONE_CNT) else $error("illegal not inert");
endmodule : mofd_decoder_chk

bind mofd_decoder mofd_decoder_chk u_chk (.*);

// ### tb/tb_mofd_decoder.sv
// self-checking bench of the move and operand field decoder
`timescale 1ns/1ps
`include "mofd_cfg.svh"
`define MOFD_CHK(n, e, g) check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end
module tb_mofd_decoder import mofd_pkg::*; ;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic valid_in, dual_par_in, src_whole_in;
    logic [2:0] op_in, mult_a_in, mult_b_in, acc_in, ptr1_in;
    logic [1:0] sign_in, add_ops_in, mode1_in, dst1_in, mode2_in, dst2_in;
    logic [3:0] src_code_in, dst_code_in;
    logic dec_valid_out, illegal_out, negate_out, clr_low_out, sat_out;
    logic [`MOFD_CAUSE_W-1:0] cause_out, x_cause;
    mofd_reg_e mult_a_sel_out, mult_b_sel_out, acc_sel_out, src_sel_out, dst_sel_out;
    mofd_reg_e x_ma, x_mb, x_acc, x_ss, x_ds;
    mofd_part_e src_part_out, dst_part_out, x_sp, x_dp;
    logic [1:0] cycles_out, words_out, x_cyc, x_wrd;
    logic x_val, x_ill, x_neg, x_clr, x_sat, x_spk, x_dpk;
    int miscompares = 0;
    int check_count = 0;
    int i;
    int c;

    mofd_decoder u_dut (.*);

    // 250 MHz core clock
    always #2 sys_clk_in = ~sys_clk_in;

    ////////////////////////////////////////////////////////////////////////////////
    // field code to register
    function automatic mofd_reg_e rmap(input logic [3:0] f);
        return mofd_reg_e'({1'b0, f} + 5'h01);
    endfunction : rmap

    // reference decode
    function automatic void model();
        logic mv, lng, ext, dr, ok, mac;
        logic [3:0] s;
        logic [3:0] d;
        s = src_code_in;
        d = dst_code_in;
        mac = op_in == `MOFD_OP_MAC;
        mv = op_in >= `MOFD_OP_MOVW && op_in <= `MOFD_OP_MOVXL;
        lng = op_in == `MOFD_OP_MOVL || op_in == `MOFD_OP_MOVXL;
        ext = op_in == `MOFD_OP_MOVXW || op_in == `MOFD_OP_MOVXL;
        dr = dual_par_in && (mac || op_in == `MOFD_OP_ADD);
        x_cause[0] = op_in == 3'h7 || (mac && (mult_a_in == 3'h4 || mult_b_in == 3'h4));
        x_cause[1] = mac && sign_in == 2'h3;
        x_cause[2] = op_in == `MOFD_OP_ADD && add_ops_in != `MOFD_ADD_OPS;
        x_cause[3] = dr && (ptr1_in == `MOFD_PTR_R2 || ptr1_in >= `MOFD_PTR_LIM);
        x_cause[4] = dr && (mode1_in == `MOFD_AM_DEC || mode1_in == `MOFD_AM_PN3);
        x_cause[5] = dr && (dst1_in == `MOFD_DD_X0 || dst1_in == `MOFD_DD_BAD);
        x_cause[6] = dr && mode2_in == `MOFD_AM_PN;
        x_cause[7] = dr && (dst2_in == `MOFD_DD_Y0 || dst2_in == `MOFD_DD_BAD);
        x_cause[8] = mv && (s == 4'hF || (s >= `MOFD_F_R0 && !ext) || (s == `MOFD_F_Y && !lng)
            || (s >= `MOFD_F_X0 && s <= `MOFD_F_Y1 && lng));
        x_cause[9] = mv && (d == 4'hF || (d >= `MOFD_F_R0 && !ext) || (d >= `MOFD_F_X0 && d <= `MOFD_F_Y1 && lng));
        if (!valid_in) x_cause = '0;
        x_val = valid_in;
        x_ill = |x_cause;
        ok = valid_in && !x_ill;
        x_neg = ok && mac && sign_in == `MOFD_SIGN_MINUS;
        x_cyc = (ok && mac) ? `MOFD_MAC_CYC : `MOFD_NONE_CNT;
        x_wrd = (ok && mac) ? `MOFD_MAC_WRD : `MOFD_NONE_CNT;
        x_ma = (ok && mac) ? rmap({1'b0, mult_a_in}) : MOFD_R_NONE;
        x_mb = (ok && mac) ? rmap({1'b0, mult_b_in}) : MOFD_R_NONE;
        x_acc = (ok && mac) ? rmap({1'b0, acc_in}) : MOFD_R_NONE;
        x_ss = (ok && mv) ? rmap(s) : MOFD_R_NONE;
        x_ds = (ok && mv) ? rmap(d) : MOFD_R_NONE;
        x_sp = !(ok && mv) ? MOFD_P_NONE : lng ? MOFD_P_LONG : (s < 4'h4 ? MOFD_P_UPPER : MOFD_P_WORD);
        x_dp = !(ok && mv) ? MOFD_P_NONE : d < 4'h4 ? MOFD_P_WHOLE : d == `MOFD_F_Y ?
            (lng ? MOFD_P_LONG : MOFD_P_UPPER) : MOFD_P_WORD;
        // agu portion in a long access is open
        x_spk = !(ok && lng && s >= `MOFD_F_R0);
        x_dpk = !(ok && lng && d >= `MOFD_F_R0);
        x_sat = ok && mv && !lng && s < 4'h4 && src_whole_in;
        x_clr = ok && mv && !lng && d == `MOFD_F_Y;
    endfunction : model

    // compare all outputs
    task automatic check_out();
        `MOFD_CHK("dec_valid", x_val, dec_valid_out)
        `MOFD_CHK("illegal", x_ill, illegal_out)
        `MOFD_CHK("cause", x_cause, cause_out)
        `MOFD_CHK("negate", x_neg, negate_out)
        `MOFD_CHK("mult_a_sel", x_ma, mult_a_sel_out)
        `MOFD_CHK("mult_b_sel", x_mb, mult_b_sel_out)
        `MOFD_CHK("acc_sel", x_acc, acc_sel_out)
        `MOFD_CHK("cycles", x_cyc, cycles_out)
        `MOFD_CHK("words", x_wrd, words_out)
        `MOFD_CHK("src_sel", x_ss, src_sel_out)
        `MOFD_CHK("dst_sel", x_ds, dst_sel_out)
        if (x_spk) begin `MOFD_CHK("src_part", x_sp, src_part_out) end
        if (x_dpk) begin `MOFD_CHK("dst_part", x_dp, dst_part_out) end
        `MOFD_CHK("clr_low", x_clr, clr_low_out)
        `MOFD_CHK("sat", x_sat, sat_out)
    endtask : check_out

    // one decode, read one edge later
    task automatic step();
        model();
        @(posedge sys_clk_in);
        #1;
        check_out();
    endtask : step

    // legal add with legal dual read
    task automatic set_ok();
        {valid_in, op_in, sign_in, mult_a_in, mult_b_in, acc_in} = {1'b1, `MOFD_OP_ADD, 2'h0, 3'h5, 3'h6, 3'h0};
        {add_ops_in, src_code_in, dst_code_in, src_whole_in, dual_par_in} = {2'h2, 4'h0, 4'h0, 1'b0, 1'b1};
        {ptr1_in, mode1_in, dst1_in, mode2_in, dst2_in} = {3'h0, 2'h0, 2'h1, 2'h0, 2'h0};
    endtask : set_ok

    task automatic rnd();
        valid_in = ($urandom % 8) != 0;
        {op_in, mult_a_in, mult_b_in, acc_in, ptr1_in} = 15'($urandom);
        {sign_in, add_ops_in, mode1_in, dst1_in, mode2_in, dst2_in} = 12'($urandom);
        {src_code_in, dst_code_in, src_whole_in, dual_par_in} = 10'($urandom);
    endtask : rnd

    task automatic test_done();
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        miscompares++;
        test_done();
    end

    initial begin
        set_ok();
        valid_in = 1'b0;
        void'($urandom(89025));
        repeat (16) @(posedge sys_clk_in);
        #1;
        sys_rst_in = 1'b0;
        // multiply: all signs and multiplicand codes
        set_ok();
        op_in = `MOFD_OP_MAC;
        for (i = 0; i < 4; i++) begin
            sign_in = i[1:0]; step();
        end
        for (i = 0; i < 8; i++) begin
            {mult_a_in, mult_b_in, acc_in} = {i[2:0], 3'(7 - i), i[2:0]}; step();
        end
        // add operand counts, then each dual read field swept alone
        for (i = 0; i < 4; i++) begin
            set_ok(); add_ops_in = i[1:0]; step();
        end
        for (i = 0; i < 8; i++) begin
            set_ok(); ptr1_in = i[2:0]; step();
            set_ok(); mode1_in = i[1:0]; step();
            set_ok(); dst1_in = i[1:0]; step();
            set_ok(); mode2_in = i[1:0]; step();
            set_ok(); dst2_in = i[1:0]; step();
        end
        // all ops by all field codes, bad dual read alongside
        for (i = 0; i < 8; i++) begin
            for (c = 0; c < 16; c++) begin
                set_ok(); ptr1_in = `MOFD_PTR_R2; op_in = i[2:0];
                {src_code_in, dst_code_in, src_whole_in} = {c[3:0], 4'(15 - c), c[0]}; step();
            end
        end
        // mid-run reset clears outputs at once
        valid_in = 1'b0;
        model();
        sys_rst_in = 1'b1;
        #1;
        check_out();
        @(posedge sys_clk_in);
        #1;
        sys_rst_in = 1'b0;
        for (i = 0; i < 3000; i++) begin
            rnd(); step();
        end
        test_done();
    end
endmodule : tb_mofd_decoder
